// [design/mals_pkg.sv]
package mals_pkg;
  // ---------------------------------------------------------------
  // port geometry
  // ---------------------------------------------------------------
  localparam int NUM_MASTERS = 4;
  localparam int NUM_LINKS   = 2;
  localparam int ADDR_W_4H   = 33;
  localparam int ADDR_W_8H   = 34;
  localparam int TAG_W       = 6;
  localparam int LEN_W       = 4;
  localparam int BURST_W     = 2;
  localparam int SIZE_W      = 3;
  localparam int DATA_W      = 256;
  localparam int FIFO_DEPTH  = 8;

  // ---------------------------------------------------------------
  // encodings and address decode
  // ---------------------------------------------------------------
  localparam logic [BURST_W-1:0] BURST_FIXED = 2'h0;
  localparam logic [BURST_W-1:0] BURST_INCR  = 2'h1;
  localparam logic [SIZE_W-1:0]  SIZE_256    = 3'h5;
  localparam int                 BEAT_BYTES  = 32;
  localparam int                 SLAVE_W     = 3;  // slave index in top address bits
  localparam int                 LATERAL_BIT = 2;  // set: slave sits in neighbour instance

  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    SW_IDLE  = 6'h01,
    SW_WAITL = 6'h02,
    SW_GAP   = 6'h04,
    SW_READ  = 6'h08,
    SW_DRAIN = 6'h10,
    SW_WRITE = 6'h20
  } mals_sw_state_type;

  typedef enum logic [2:0] {
    MS_IDLE = 3'h1,
    MS_ADDR = 3'h2,
    MS_DATA = 3'h4
  } mals_ms_state_type;
endpackage : mals_pkg

// [design/mals_if.sv]
`timescale 1ns/1ps
interface mals_if #(
  parameter int ADDR_W = mals_pkg::ADDR_W_4H,
  parameter int DATA_W = mals_pkg::DATA_W
) (
  input wire logic sys_clk
);
  localparam int NM = mals_pkg::NUM_MASTERS;
  // ---------------------------------------------------------------
  // per master channels, index is the master number
  // ---------------------------------------------------------------
  logic [NM-1:0]                    port_reset_low;
  logic [NM-1:0]                    port_read_request_valid;
  logic [NM-1:0]                    port_read_request_ready;
  logic [ADDR_W-1:0]                port_read_address    [NM];
  logic [mals_pkg::BURST_W-1:0]     port_read_burst_type [NM];
  logic [mals_pkg::TAG_W-1:0]       port_read_tag        [NM];
  logic [mals_pkg::LEN_W-1:0]       port_read_length     [NM];
  logic [mals_pkg::SIZE_W-1:0]      port_read_beat_size  [NM];
  logic [NM-1:0]                    write_request_valid;
  logic [NM-1:0]                    write_request_ready;
  logic [ADDR_W-1:0]                write_address        [NM];
  logic [mals_pkg::TAG_W-1:0]       write_tag            [NM];
  logic [mals_pkg::LEN_W-1:0]       write_length         [NM];
  logic [NM-1:0]                    write_valid;
  logic [NM-1:0]                    write_ready;
  logic [NM-1:0]                    write_last;
  logic [DATA_W-1:0]                write_data           [NM];
  logic [NM-1:0]                    read_valid;
  logic [NM-1:0]                    read_ready;
  logic [NM-1:0]                    read_last;
  logic [mals_pkg::TAG_W-1:0]       read_tag             [NM];
  logic [DATA_W-1:0]                read_data            [NM];

  modport switch_end (
    input  port_reset_low, port_read_request_valid, port_read_address,
    input  port_read_burst_type, port_read_tag, port_read_length, port_read_beat_size,
    input  write_request_valid, write_address, write_tag, write_length,
    input  write_valid, write_last, write_data, read_ready,
    output port_read_request_ready, write_request_ready, write_ready,
    output read_valid, read_last, read_tag, read_data
  );

  modport master_end (
    output port_reset_low, port_read_request_valid, port_read_address,
    output port_read_burst_type, port_read_tag, port_read_length, port_read_beat_size,
    output write_request_valid, write_address, write_tag, write_length,
    output write_valid, write_last, write_data, read_ready,
    input  port_read_request_ready, write_request_ready, write_ready,
    input  read_valid, read_last, read_tag, read_data
  );
endinterface : mals_if

// [design/mals_switch.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// read return buffer
// ---------------------------------------------------------------
module mals_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = mals_pkg::FIFO_DEPTH
) (
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // honest full and empty from the fill count
  assign in_ready  = (cnt_r != FULL_CNT);
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointers and count
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (push) wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      if (pop)  rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      if (push && !pop) cnt_r <= cnt_r + 1'b1;
      else if (pop && !push) cnt_r <= cnt_r - 1'b1;
    end
  end

  // storage, data only, no reset needed
  always_ff @(posedge sys_clk) begin
    if (push) mem[wr_ptr_r] <= in_data;
  end
endmodule : mals_fifo

module mals_switch #(
  parameter int ADDR_W = mals_pkg::ADDR_W_4H,
  parameter int DATA_W = mals_pkg::DATA_W
) (
  input  wire logic                             sys_clk,
  input  wire logic                             arst_n,
  mals_if.switch_end                            bus,
  output      logic [mals_pkg::NUM_LINKS-1:0]   link_busy,
  output      logic [mals_pkg::NUM_LINKS-1:0]   link_owner,
  output      logic [mals_pkg::NUM_MASTERS-1:0] write_beat_seen
);
  localparam int NM     = mals_pkg::NUM_MASTERS;
  localparam int TAG_W  = mals_pkg::TAG_W;
  localparam int LEN_W  = mals_pkg::LEN_W;
  localparam int FIFO_W = DATA_W + TAG_W + 1;

  logic          rst_n;
  logic [NM-1:0] want;
  logic [NM-1:0] grant;
  logic [NM-1:0] release_link;
  logic [NM-1:0] gap_need;

  // ---------------------------------------------------------------
  // joined reset
  // ---------------------------------------------------------------
  assign rst_n = arst_n & (&bus.port_reset_low);

  // ---------------------------------------------------------------
  // per master port
  // ---------------------------------------------------------------
  for (genvar m = 0; m < NM; m++) begin : g_port
    mals_pkg::mals_sw_state_type state_r;
    logic                        lat_r;
    logic                        phase_r;
    logic                        ar_ready_r;
    logic                        aw_ready_r;
    logic                        w_ready_r;
    logic                        seen_r;
    logic [LEN_W-1:0]            cnt_r;
    logic [ADDR_W-1:0]           addr_r;
    logic [TAG_W-1:0]            tag_r;
    logic                        ar_hs;
    logic                        aw_hs;
    logic                        w_hs;
    logic                        w_end;
    logic                        r_end;
    logic                        ar_lat;
    logic                        aw_lat;
    logic                        push;
    logic                        fin_ready;
    logic                        fout_valid;
    logic [FIFO_W-1:0]           fin_data;
    logic [FIFO_W-1:0]           fout_data;

    // handshakes and slave decode from the top address bits
    assign ar_hs  = bus.port_read_request_valid[m] & ar_ready_r;
    assign aw_hs  = bus.write_request_valid[m] & aw_ready_r;
    assign w_hs   = bus.write_valid[m] & w_ready_r;
    assign w_end  = w_hs & bus.write_last[m];
    assign r_end  = fout_valid & bus.read_ready[m] & fout_data[FIFO_W-1];
    assign ar_lat = bus.port_read_address[m][ADDR_W-1-(mals_pkg::SLAVE_W-1-mals_pkg::LATERAL_BIT)];
    assign aw_lat = bus.write_address[m][ADDR_W-1-(mals_pkg::SLAVE_W-1-mals_pkg::LATERAL_BIT)];
    assign want[m] = (state_r == mals_pkg::SW_WAITL) | (state_r == mals_pkg::SW_GAP);
    assign release_link[m] = lat_r & (((state_r == mals_pkg::SW_DRAIN) & r_end) |
                                      ((state_r == mals_pkg::SW_WRITE) & w_end));
    // lateral beats only on alternate cycles, local beats every cycle
    assign push = (state_r == mals_pkg::SW_READ) & fin_ready & (~lat_r | phase_r);
    assign fin_data = {(cnt_r == '0), tag_r, {(DATA_W-ADDR_W){1'b0}}, addr_r};

    assign bus.port_read_request_ready[m] = ar_ready_r;
    assign bus.write_request_ready[m]     = aw_ready_r;
    assign bus.write_ready[m]             = w_ready_r;
    assign bus.read_valid[m]              = fout_valid;
    assign bus.read_last[m]               = fout_data[FIFO_W-1];
    assign bus.read_tag[m]                = fout_data[FIFO_W-2 -: TAG_W];
    assign bus.read_data[m]               = fout_data[DATA_W-1:0];
    assign write_beat_seen[m]             = seen_r;

    // transaction sequencing; readies alternate in idle, lateral writes wait in gap
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        state_r    <= mals_pkg::SW_IDLE;
        ar_ready_r <= 1'b1;
        aw_ready_r <= 1'b0;
        w_ready_r  <= 1'b0;
        lat_r      <= 1'b0;
        cnt_r      <= '0;
        addr_r     <= '0;
        tag_r      <= '0;
      end else begin
        unique case (state_r)
          mals_pkg::SW_IDLE: begin
            if (ar_hs) begin
              ar_ready_r <= 1'b0;
              aw_ready_r <= 1'b0;
              lat_r      <= ar_lat;
              addr_r     <= bus.port_read_address[m];
              cnt_r      <= bus.port_read_length[m];
              tag_r      <= bus.port_read_tag[m];
              state_r    <= ar_lat ? mals_pkg::SW_WAITL : mals_pkg::SW_READ;
            end else if (aw_hs) begin
              ar_ready_r <= 1'b0;
              aw_ready_r <= 1'b0;
              lat_r      <= aw_lat;
              w_ready_r  <= ~aw_lat;
              state_r    <= aw_lat ? mals_pkg::SW_GAP : mals_pkg::SW_WRITE;
            end else begin
              ar_ready_r <= ~ar_ready_r;
              aw_ready_r <= ar_ready_r;
            end
          end
          mals_pkg::SW_WAITL: begin
            if (grant[m]) state_r <= mals_pkg::SW_READ;
          end
          mals_pkg::SW_GAP: begin
            if (grant[m]) begin
              w_ready_r <= ~gap_need[m];
              state_r   <= mals_pkg::SW_WRITE;
            end
          end
          mals_pkg::SW_READ: begin
            if (push && cnt_r == '0) state_r <= mals_pkg::SW_DRAIN;
            else if (push) cnt_r <= cnt_r - 1'b1;
          end
          mals_pkg::SW_DRAIN: begin
            if (r_end) state_r <= mals_pkg::SW_IDLE;
          end
          mals_pkg::SW_WRITE: begin
            w_ready_r <= ~w_end;
            if (w_end) state_r <= mals_pkg::SW_IDLE;
          end
          default: state_r <= mals_pkg::SW_IDLE;
        endcase
      end
    end

    // lateral rate phase
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) phase_r <= 1'b1;
      else phase_r <= (state_r == mals_pkg::SW_READ && lat_r) ? ~phase_r : 1'b1;
    end

    // accepted write beat indication
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) seen_r <= 1'b0;
      else seen_r <= w_hs;
    end

    mals_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (mals_pkg::FIFO_DEPTH)
    ) u_ret (
      .sys_clk   (sys_clk),
      .arst_n    (rst_n),
      .in_valid  (push),
      .in_ready  (fin_ready),
      .in_data   (fin_data),
      .out_valid (fout_valid),
      .out_ready (bus.read_ready[m]),
      .out_data  (fout_data)
    );
  end

  // ---------------------------------------------------------------
  // lateral link arbitration, link l serves masters 2l and 2l+1
  // ---------------------------------------------------------------
  for (genvar l = 0; l < mals_pkg::NUM_LINKS; l++) begin : g_link
    localparam int A = 2 * l;
    localparam int B = 2 * l + 1;
    logic busy_r;
    logic owner_r;
    logic had_r;
    logic pick;

    // round robin when both ask, otherwise whoever asks
    assign pick     = (want[A] & want[B]) ? ~owner_r : want[B];
    assign grant[A] = ~busy_r & want[A] & ~pick;
    assign grant[B] = ~busy_r & want[B] & pick;
    // previous owner differs from the new one: one dead cycle for writes
    assign gap_need[A] = had_r & owner_r;
    assign gap_need[B] = had_r & ~owner_r;
    assign link_busy[l]  = busy_r;
    assign link_owner[l] = owner_r;

    // claim on grant, free only when the owner's burst is done
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        busy_r  <= 1'b0;
        owner_r <= 1'b0;
        had_r   <= 1'b0;
      end else if (grant[A] | grant[B]) begin
        busy_r  <= 1'b1;
        owner_r <= pick;
        had_r   <= 1'b1;
      end else if (release_link[A] | release_link[B]) begin
        busy_r  <= 1'b0;
      end
    end
  end
endmodule : mals_switch

// [design/mals_master.sv]
`timescale 1ns/1ps
module mals_master #(
  parameter int ADDR_W = mals_pkg::ADDR_W_4H,
  parameter int DATA_W = mals_pkg::DATA_W
) (
  input  wire logic                             sys_clk,
  input  wire logic                             arst_n,
  mals_if.master_end                            bus,
  input  wire logic [mals_pkg::NUM_MASTERS-1:0] cmd_valid,
  input  wire logic [mals_pkg::NUM_MASTERS-1:0] cmd_write,
  input  wire logic [ADDR_W-1:0]                cmd_addr [mals_pkg::NUM_MASTERS],
  input  wire logic [mals_pkg::LEN_W-1:0]       cmd_len  [mals_pkg::NUM_MASTERS],
  input  wire logic [mals_pkg::TAG_W-1:0]       cmd_tag  [mals_pkg::NUM_MASTERS],
  output      logic [mals_pkg::NUM_MASTERS-1:0] cmd_ready,
  input  wire logic [mals_pkg::NUM_MASTERS-1:0] rd_ready,
  output      logic [mals_pkg::NUM_MASTERS-1:0] rd_valid,
  output      logic [mals_pkg::NUM_MASTERS-1:0] rd_last,
  output      logic [mals_pkg::TAG_W-1:0]       rd_tag   [mals_pkg::NUM_MASTERS],
  output      logic [DATA_W-1:0]                rd_data  [mals_pkg::NUM_MASTERS]
);
  localparam int NM    = mals_pkg::NUM_MASTERS;
  localparam int TAG_W = mals_pkg::TAG_W;
  localparam int LEN_W = mals_pkg::LEN_W;

  logic reset_low_r;

  // ---------------------------------------------------------------
  // port reset: low while our own reset is held and until the first clock edge after its release
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) reset_low_r <= 1'b0;
    else reset_low_r <= 1'b1;
  end

  for (genvar m = 0; m < NM; m++) begin : g_port
    mals_pkg::mals_ms_state_type state_r;
    logic              ready_r;
    logic              ar_valid_r;
    logic              aw_valid_r;
    logic              w_valid_r;
    logic              w_last_r;
    logic              r_ready_r;
    logic              r_valid_r;
    logic              r_last_r;
    logic [TAG_W-1:0]  r_tag_r;
    logic [DATA_W-1:0] r_data_r;
    logic [ADDR_W-1:0] addr_r;
    logic [LEN_W-1:0]  len_r;
    logic [LEN_W-1:0]  cnt_r;
    logic [TAG_W-1:0]  tag_r;

    assign bus.port_reset_low[m]          = reset_low_r;
    assign bus.port_read_request_valid[m] = ar_valid_r;
    assign bus.port_read_address[m]       = addr_r;
    assign bus.port_read_burst_type[m]    = mals_pkg::BURST_INCR;
    assign bus.port_read_tag[m]           = tag_r;
    assign bus.port_read_length[m]        = len_r;
    assign bus.port_read_beat_size[m]     = mals_pkg::SIZE_256;
    assign bus.write_request_valid[m]     = aw_valid_r;
    assign bus.write_address[m]           = addr_r;
    assign bus.write_tag[m]               = tag_r;
    assign bus.write_length[m]            = len_r;
    assign bus.write_valid[m]             = w_valid_r;
    assign bus.write_last[m]              = w_last_r;
    assign bus.write_data[m]              = {{(DATA_W-TAG_W-LEN_W){1'b0}}, tag_r, cnt_r};
    assign bus.read_ready[m]              = r_ready_r;
    assign cmd_ready[m]                   = ready_r;
    assign rd_valid[m]                    = r_valid_r;
    assign rd_last[m]                     = r_last_r;
    assign rd_tag[m]                      = r_tag_r;
    assign rd_data[m]                     = r_data_r;

    // command issue; write data is generated here, so it is ready at once
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        state_r    <= mals_pkg::MS_IDLE;
        ready_r    <= 1'b0;
        ar_valid_r <= 1'b0;
        aw_valid_r <= 1'b0;
        w_valid_r  <= 1'b0;
        w_last_r   <= 1'b0;
        addr_r     <= '0;
        len_r      <= '0;
        cnt_r      <= '0;
        tag_r      <= '0;
      end else begin
        unique case (state_r)
          mals_pkg::MS_IDLE: begin
            ready_r <= 1'b1;
            if (cmd_valid[m] && ready_r) begin
              ready_r    <= 1'b0;
              ar_valid_r <= ~cmd_write[m];
              aw_valid_r <= cmd_write[m];
              addr_r     <= cmd_addr[m];
              len_r      <= cmd_len[m];
              tag_r      <= cmd_tag[m];
              state_r    <= mals_pkg::MS_ADDR;
            end
          end
          mals_pkg::MS_ADDR: begin
            // hold the request until the far end takes it
            if (ar_valid_r && bus.port_read_request_ready[m]) begin
              ar_valid_r <= 1'b0;
              state_r    <= mals_pkg::MS_IDLE;
            end else if (aw_valid_r && bus.write_request_ready[m]) begin
              aw_valid_r <= 1'b0;
              w_valid_r  <= 1'b1;
              w_last_r   <= (len_r == '0);
              cnt_r      <= '0;
              state_r    <= mals_pkg::MS_DATA;
            end
          end
          mals_pkg::MS_DATA: begin
            if (w_valid_r && bus.write_ready[m]) begin
              if (w_last_r) begin
                w_valid_r <= 1'b0;
                w_last_r  <= 1'b0;
                state_r   <= mals_pkg::MS_IDLE;
              end else begin
                cnt_r    <= cnt_r + 1'b1;
                w_last_r <= (cnt_r + 1'b1 == len_r);
              end
            end
          end
        endcase
      end
    end

    // read return towards the user, one register stage
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        r_ready_r <= 1'b0;
        r_valid_r <= 1'b0;
        r_last_r  <= 1'b0;
        r_tag_r   <= '0;
        r_data_r  <= '0;
      end else begin
        r_ready_r <= rd_ready[m];
        r_valid_r <= bus.read_valid[m] & r_ready_r;
        if (bus.read_valid[m] && r_ready_r) begin
          r_last_r <= bus.read_last[m];
          r_tag_r  <= bus.read_tag[m];
          r_data_r <= bus.read_data[m];
        end
      end
    end
  end
endmodule : mals_master

// [verification/mals_chk.sv]
`timescale 1ns/1ps
module mals_chk #(
  parameter int ADDR_W = 33,
  parameter int DATA_W = 256
) (
  input wire logic              sys_clk,
  input wire logic              arst_n,
  input wire logic [3:0]        port_reset_low,
  input wire logic [3:0]        port_read_request_valid,
  input wire logic [3:0]        port_read_request_ready,
  input wire logic [ADDR_W-1:0] port_read_address [4],
  input wire logic [1:0]        port_read_burst_type [4],
  input wire logic [2:0]        port_read_beat_size [4],
  input wire logic [5:0]        port_read_tag [4],
  input wire logic [3:0]        port_read_length [4],
  input wire logic [3:0]        write_request_valid,
  input wire logic [3:0]        write_request_ready,
  input wire logic [3:0]        write_ready,
  input wire logic [3:0]        read_valid,
  input wire logic [3:0]        read_ready,
  input wire logic [3:0]        read_last,
  input wire logic [5:0]        read_tag [4],
  input wire logic [DATA_W-1:0] read_data [4]
);
  logic [5:0] tag_r;
  logic [3:0] len_r;
  logic [3:0] cnt_r;
  wire logic  ar0 = port_read_request_valid[0] & port_read_request_ready[0];
  wire logic  rb0 = read_valid[0] & read_ready[0];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // remember tag and length of the read in flight on master 0
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tag_r <= '0;
      len_r <= '0;
    end else if (ar0) begin
      tag_r <= port_read_tag[0];
      len_r <= port_read_length[0];
    end
  end
  // count returned beats of that read
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) cnt_r <= '0;
    else if (ar0) cnt_r <= '0;
    else if (rb0) cnt_r <= cnt_r + 4'h1;
  end
  property p_ar_hold;
    port_read_request_valid[0] && !port_read_request_ready[0]
      |=> port_read_request_valid[0] && $stable(port_read_address[0]);
  endproperty
  a_ar_hold: assert property (p_ar_hold) else $error("read request dropped");
  property p_ar_size;
    port_read_request_valid[0] |-> port_read_beat_size[0] == 3'h5;
  endproperty
  a_ar_size: assert property (p_ar_size) else $error("bad beat size");
  property p_ar_burst;
    port_read_request_valid[0] |-> port_read_burst_type[0] != 2'h0;
  endproperty
  a_ar_burst: assert property (p_ar_burst) else $error("fixed burst sent");
  property p_ar_refuse;
    ar0 |=> !port_read_request_ready[0];
  endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("second read taken");
  property p_rd_tag;
    read_valid[0] |-> read_tag[0] == tag_r;
  endproperty
  a_rd_tag: assert property (p_rd_tag) else $error("read tag wrong");
  property p_rd_last;
    rb0 && read_last[0] |-> cnt_r == len_r;
  endproperty
  a_rd_last: assert property (p_rd_last) else $error("last on wrong beat");
  property p_rd_stall;
    read_valid[0] && !read_ready[0] |=> read_valid[0] && $stable(read_data[0]);
  endproperty
  a_rd_stall: assert property (p_rd_stall) else $error("stalled beat lost");
  property p_wr_hold;
    write_request_valid[2] && write_request_ready[2] |=> !write_request_ready[2];
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write path not held");
  property p_rst_join;
    !(&port_reset_low) |-> read_valid == 4'h0 && write_ready == 4'h0;
  endproperty
  a_rst_join: assert property (p_rst_join) else $error("port reset not joined");
endmodule : mals_chk

// [verification/mals_switch_test.sv]
`timescale 1ns/1ps
module mals_switch_test;
  localparam int AW = mals_pkg::ADDR_W_4H;
  logic          sys_clk = 1'b0;
  logic          arst_n = 1'b0;
  logic [3:0]    cmd_valid = '0;
  logic [3:0]    cmd_write = '0;
  logic [3:0]    rd_ready = '1;
  logic [AW-1:0] cmd_addr [4] = '{default: '0};
  logic [3:0]    cmd_len [4] = '{default: '0};
  logic [5:0]    cmd_tag [4] = '{default: '0};
  logic [3:0]    cmd_ready, rd_valid, rd_last, wbs;
  logic [1:0]    link_busy, link_own;
  logic [5:0]    rd_tag [4];
  logic [255:0]  rd_data [4];
  logic          stall = 1'b0;
  int            n_errors = 0;
  int            checks_done = 0;
  int            wcount = 0;
  int            cyc = 0;
  int            sp;
  // ---------------------------------------------------------------
  // clock, stall pattern, counters
  // ---------------------------------------------------------------
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) rd_ready <= stall ? ~rd_ready : 4'hf;
  always @(posedge sys_clk) wcount <= wcount + $countones(wbs);
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  mals_if #(.ADDR_W(AW)) i_mals_if (.sys_clk(sys_clk));
  mals_switch #(.ADDR_W(AW)) i_mals_switch (.sys_clk(sys_clk), .arst_n(arst_n),
    .bus(i_mals_if.switch_end), .link_busy(link_busy), .link_owner(link_own),
    .write_beat_seen(wbs));
  mals_master #(.ADDR_W(AW)) i_mals_master (.sys_clk(sys_clk), .arst_n(arst_n),
    .bus(i_mals_if.master_end), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_tag(cmd_tag), .cmd_ready(cmd_ready),
    .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_last(rd_last), .rd_tag(rd_tag),
    .rd_data(rd_data));
  mals_chk #(.ADDR_W(AW)) i_mals_chk (.sys_clk(sys_clk), .arst_n(arst_n),
    .port_reset_low(i_mals_if.port_reset_low),
    .port_read_request_valid(i_mals_if.port_read_request_valid),
    .port_read_request_ready(i_mals_if.port_read_request_ready),
    .port_read_address(i_mals_if.port_read_address),
    .port_read_burst_type(i_mals_if.port_read_burst_type),
    .port_read_beat_size(i_mals_if.port_read_beat_size),
    .port_read_tag(i_mals_if.port_read_tag), .port_read_length(i_mals_if.port_read_length),
    .write_request_valid(i_mals_if.write_request_valid),
    .write_request_ready(i_mals_if.write_request_ready),
    .write_ready(i_mals_if.write_ready), .read_valid(i_mals_if.read_valid),
    .read_ready(i_mals_if.read_ready), .read_last(i_mals_if.read_last),
    .read_tag(i_mals_if.read_tag), .read_data(i_mals_if.read_data));
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic send(input int m, input logic w, input logic [AW-1:0] a,
                      input logic [3:0] l, input logic [5:0] t);
    int n;
    n = 0;
    cmd_addr[m] <= a;
    cmd_len[m] <= l;
    cmd_tag[m] <= t;
    cmd_write[m] <= w;
    cmd_valid[m] <= 1'b1;
    do @(posedge sys_clk); while (cmd_ready[m] !== 1'b1 && ++n < 200);
    cmd_valid[m] <= 1'b0;
  endtask : send
  task automatic rd(input int m, input logic [AW-1:0] a, input logic [3:0] l,
                    input logic [5:0] t, output int span);
    int b;
    int f;
    b = 0;
    send(m, 1'b0, a, l, t);
    for (int c = 0; c < 400 && b <= l; c++) begin
      @(posedge sys_clk);
      if (rd_valid[m] === 1'b1) begin
        if (b == 0) f = c;
        chk("rd_tag", t, rd_tag[m]);
        chk("rd_data", a, rd_data[m][AW-1:0]);
        chk("rd_last", b == l, rd_last[m]);
        span = c - f;
        b++;
      end
    end
    chk("rd_beats", 64'(l) + 1, b);
  endtask : rd
  task automatic wr(input int m, input logic [AW-1:0] a, input logic [3:0] l);
    int n0;
    n0 = wcount;
    send(m, 1'b1, a, l, 6'h2a);
    repeat (200) if (wcount < n0 + l + 1) @(posedge sys_clk);
    chk("wr_beats", 64'(l) + 1, wcount - n0);
  endtask : wr
  task automatic end_of_test();
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int s = 0; s < 8; s++) begin
      rd(0, {s[2:0], 30'h40}, 4'h3, 6'(s), sp);
      if (s[2]) chk("lat_span", 6, sp);
      else chk("loc_span", 3, sp);
    end
    rd(2, {3'h1, 30'h80}, 4'h2, 6'h11, sp);
    rd(2, {3'h5, 30'h80}, 4'h2, 6'h12, sp);
    stall <= 1'b1;
    rd(0, {3'h7, 30'h100}, 4'h7, 6'h3f, sp);
    stall <= 1'b0;
    chk("link_free", 0, link_busy[0]);
    wr(2, {3'h6, 30'h200}, 4'h3);
    wr(3, {3'h5, 30'h300}, 4'h0);
    chk("link_owner", 1, link_own[1]);
    wr(2, {3'h1, 30'h400}, 4'hf);
    end_of_test();
  end
endmodule : mals_switch_test
